// [hw/smf_pkg.sv]
package smf_pkg;

   // Channel count and widths of the input module.
   localparam int N_CH = 6;
   localparam int N_PAIR = 3;
   localparam int SAMPLE_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int HIST_DEPTH = 64;

   // Register offsets on the plain register port.
   localparam logic [3:0] ADDR_SMOOTH = 4'h0;
   localparam logic [3:0] ADDR_EVAL = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_TOL_ABS = 4'h4;
   localparam logic [3:0] ADDR_TOL_REL = 4'h8;

   // Status field positions.
   localparam int STAT_PRIMED_LSB = 0;
   localparam int STAT_HART_LSB = 8;
   localparam int STAT_DISC_LSB = 16;
   localparam int STAT_ROLE_BIT = 24;

   // Reset values; tolerances are held in steps of 0.1 percent.
   localparam logic [1:0] SMOOTH_RST = 2'h0;
   localparam logic [7:0] TOL_RST = 8'h19;
   localparam logic [7:0] TOL_MIN = 8'h02;
   localparam logic [7:0] TOL_MAX = 8'hC8;

   // Loop current scaling; the full scale code is a plain default.
   localparam int FULL_SCALE_UA = 20000;
   localparam int HART_MIN_UA = 1170;
   localparam logic [15:0] FULL_SCALE_CODE = 16'h7000;
   localparam logic [15:0] HART_MIN_CODE =
      16'(int'(FULL_SCALE_CODE) * HART_MIN_UA / FULL_SCALE_UA);

   // Smoothing level codes: window of 1, 4, 16 or 64 samples.
   typedef enum logic [1:0] {LVL_1, LVL_4, LVL_16, LVL_64} level_e;

endpackage

// [hw/avg_if.sv]
`timescale 1ns/10ps
// Link between the channel sequencer and one channel's averager.
interface avg_if;
   logic push; // New good sample for this channel.
   logic restart; // Drop the window and start counting again.
   logic [1:0] level; // Smoothing level code.
   logic [15:0] sample; // Converted sample.
   logic [15:0] mean; // Mean of the current window.
   logic primed; // A full window has been collected.
   modport ctrl(output push, restart, level, sample, input mean, primed);
   modport filt(input push, restart, level, sample, output mean, primed);
endinterface // avg_if

// [hw/sample_fifo.sv]
`timescale 1ns/10ps
module sample_fifo #(
   parameter int W = 22,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH]; // Storage words.
   logic [PW:0] wp, next_wp; // Write pointer with wrap bit.
   logic [PW:0] rp, next_rp; // Read pointer with wrap bit.
   logic full;
   logic empty;

   ////////////////////////////////////////////////////////////////////////
   // Full and empty compare the pointers; the wrap bit tells them apart.
   always_comb begin
      empty = (wp == rp);
      full = (wp[PW-1:0] == rp[PW-1:0]) && (wp[PW] != rp[PW]);
      in_ready = !full;
      out_valid = !empty;
      out_data = mem[rp[PW-1:0]];
      next_wp = wp;
      next_rp = rp;
      if (in_valid && !full) begin
         next_wp = wp + 1'b1;
      end
      if (out_ready && !empty) begin
         next_rp = rp + 1'b1;
      end
   end

   // Pointers only; the storage has no reset as it is never read empty.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wp <= '0;
         rp <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
      end
   end

   // Storage write.
   always_ff @(posedge clock) begin
      if (in_valid && !full) begin
         mem[wp[PW-1:0]] <= in_data;
      end
   end
endmodule // sample_fifo

// [hw/chan_avg.sv]
`timescale 1ns/10ps
module chan_avg #(
   parameter int W = 16,
   parameter int DEPTH = 64
) (
   input wire logic clock,
   input wire logic nrst,
   avg_if.filt port
);
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0] hist [DEPTH]; // Ring of the most recent samples.
   logic [PW-1:0] wp, next_wp; // Next ring slot to write.
   logic [PW:0] cnt, next_cnt; // Samples collected since restart, held once it reaches the window length.
   logic [W+PW-1:0] sum, next_sum; // Running sum of the window.
   logic [PW:0] len; // Window length for the level.
   logic [W-1:0] oldest; // Sample that leaves the window.

   ////////////////////////////////////////////////////////////////////////
   // Running sum: fill the window, then add the new and drop the oldest.
   // With a 64 window the oldest slot is the one about to be rewritten.
   always_comb begin
      len = (PW+1)'(1) << {port.level, 1'b0};
      oldest = hist[wp - len[PW-1:0]];
      next_wp = wp;
      next_cnt = cnt;
      next_sum = sum;
      if (port.restart) begin
         // Restart wins over a push in the same cycle.
         next_cnt = '0;
         next_sum = '0;
      end else if (port.push) begin
         next_wp = wp + 1'b1;
         if (cnt < len) begin
            next_cnt = cnt + 1'b1;
            next_sum = sum + port.sample;
         end else begin
            next_sum = sum + port.sample - oldest;
         end
      end
   end

   // Mean is a shift since every window is a power of two; level 1 is a
   // plain pass-through of the last sample at level 0.
   assign port.mean = W'(sum >> {port.level, 1'b0});
   assign port.primed = (cnt == len);

   // Window state.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wp <= '0;
         cnt <= '0;
         sum <= '0;
      end else begin
         wp <= next_wp;
         cnt <= next_cnt;
         sum <= next_sum;
      end
   end

   // Sample history.
   always_ff @(posedge clock) begin
      if (port.push && !port.restart) begin
         hist[wp] <= port.sample;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   window_fill_a: assert property (
      port.push && !port.restart && cnt == len - 1'b1 |=> port.primed)
      else $error("window not primed after its last sample");
   slide_sum_a: assert property (
      port.push && !port.restart && port.primed && $stable(port.level)
      |=> sum == $past(sum) + $past(port.sample) - $past(oldest))
      else $error("running sum did not slide");
endmodule // chan_avg

// [hw/channel_smoothing_filter.sv]
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/10ps
// Function
// - Smoothing over 1, 4, 16 or 64 samples.
// - Output is mean of latest samples.
// - Window of one passes samples unchanged.
// - Restart on startup, fault, range exit.
// - Withhold value until window is full.
// - Discrepancy never restarts the smoothing.
// - Discrepancy check sees smoothed values.
// - Absolute tolerance 0.2 to 20, default 2.5.
// - Relative tolerance 0.2 to 20, default 2.5.
// - Suspend field bus below 1.17 mA.
// - Higher start address becomes secondary master.
module channel_smoothing_filter #(
   parameter int N_CH = smf_pkg::N_CH,
   parameter int N_PAIR = smf_pkg::N_PAIR,
   parameter int W = smf_pkg::SAMPLE_W,
   parameter int FIFO_DEPTH = smf_pkg::FIFO_DEPTH,
   parameter int HIST_DEPTH = smf_pkg::HIST_DEPTH
) (
   input wire logic clock,
   input wire logic nrst,
   // Samples from the converter sequencer.
   input wire logic s_valid,
   output logic s_ready,
   input wire logic [2:0] s_ch,
   input wire logic [W-1:0] s_data,
   input wire logic s_short,
   input wire logic s_wire_break,
   input wire logic s_out_of_range,
   // Process values to the fail-safe controller.
   output logic p_valid,
   input wire logic p_ready,
   output logic [2:0] p_ch,
   output logic [W-1:0] p_value,
   // Smoothed values and pair settings for the discrepancy check.
   output logic [N_CH*W-1:0] smoothed_values,
   output logic [N_CH-1:0] smoothed_primed,
   output logic [N_PAIR-1:0] dual_eval,
   output logic [N_PAIR*8-1:0] tol_abs_values,
   output logic [N_PAIR*8-1:0] tol_rel_values,
   input wire logic [N_PAIR-1:0] discrepancy,
   // Field bus gate per channel.
   output logic [N_CH-1:0] hart_enable,
   // Redundancy role.
   input wire logic redundant,
   input wire logic [9:0] start_addr,
   input wire logic [9:0] partner_addr,
   output logic secondary_master,
   // Register port.
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);
   localparam int FW = 3 + 2 + W;

   ////////////////////////////////////////////////////////////////////////
   // Input buffer.

   logic [FW-1:0] f_data; // Buffered sample word.
   logic f_valid; // Buffer holds a sample.
   logic f_ready; // Filter takes the buffered sample.
   logic [2:0] f_ch; // Channel of the buffered sample.
   logic f_fault; // Short circuit or wire break.
   logic f_oor; // Outside the measuring range.
   logic [W-1:0] f_sample; // Converted value.

   // A stalled controller backs up into this buffer and then into the
   // sequencer through s_ready.
   sample_fifo #(
      .W(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .nrst(nrst),
      .in_valid(s_valid),
      .in_ready(s_ready),
      .in_data({s_ch, s_short | s_wire_break, s_out_of_range, s_data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   assign {f_ch, f_fault, f_oor, f_sample} = f_data;

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers.

   logic [N_CH-1:0][1:0] lvl, next_lvl; // Smoothing level per channel.
   logic [N_PAIR-1:0] dual, next_dual; // Pair uses dual evaluation.
   logic [N_PAIR-1:0][7:0] tol_abs, next_abs; // Absolute window.
   logic [N_PAIR-1:0][7:0] tol_rel, next_rel; // Relative window.
   logic [31:0] next_rdata; // Read answer for the next cycle.
   logic [N_CH-1:0] lvl_chg; // A write changes a channel's level.
   logic [N_CH-1:0] primed; // Window full per channel.
   logic [N_CH-1:0] hart_ok, next_hart; // Loop current high enough.
   logic secondary, next_secondary; // Redundancy role.

   // Settings outside the allowed span are pulled to the nearest end.
   function automatic logic [7:0] clamp_tol(input logic [7:0] v);
      if (v < smf_pkg::TOL_MIN) begin
         clamp_tol = smf_pkg::TOL_MIN;
      end else if (v > smf_pkg::TOL_MAX) begin
         clamp_tol = smf_pkg::TOL_MAX;
      end else begin
         clamp_tol = v;
      end
   endfunction

   // Register writes and the read answer.
   always_comb begin
      next_lvl = lvl;
      next_dual = dual;
      next_abs = tol_abs;
      next_rel = tol_rel;
      next_rdata = '0;
      lvl_chg = '0;
      if (wr && addr == smf_pkg::ADDR_SMOOTH) begin
         for (int i = 0; i < N_CH; i++) begin
            next_lvl[i] = wdata[2*i +: 2];
            // A new level restarts that channel's window.
            lvl_chg[i] = (wdata[2*i +: 2] != lvl[i]);
         end
      end
      if (wr && addr == smf_pkg::ADDR_EVAL) begin
         next_dual = wdata[N_PAIR-1:0];
      end
      for (int k = 0; k < N_PAIR; k++) begin
         if (wr && addr == smf_pkg::ADDR_TOL_ABS + 4'(k)) begin
            next_abs[k] = clamp_tol(wdata[7:0]);
         end
         if (wr && addr == smf_pkg::ADDR_TOL_REL + 4'(k)) begin
            next_rel[k] = clamp_tol(wdata[7:0]);
         end
         if (rd && addr == smf_pkg::ADDR_TOL_ABS + 4'(k)) begin
            next_rdata = 32'(tol_abs[k]);
         end
         if (rd && addr == smf_pkg::ADDR_TOL_REL + 4'(k)) begin
            next_rdata = 32'(tol_rel[k]);
         end
      end
      if (rd && addr == smf_pkg::ADDR_SMOOTH) begin
         next_rdata = 32'(lvl);
      end
      if (rd && addr == smf_pkg::ADDR_EVAL) begin
         next_rdata = 32'(dual);
      end
      if (rd && addr == smf_pkg::ADDR_STATUS) begin
         next_rdata[smf_pkg::STAT_PRIMED_LSB +: N_CH] = primed;
         next_rdata[smf_pkg::STAT_HART_LSB +: N_CH] = hart_ok;
         next_rdata[smf_pkg::STAT_DISC_LSB +: N_PAIR] = discrepancy;
         next_rdata[smf_pkg::STAT_ROLE_BIT] = secondary;
      end
   end

   // Configuration state; tolerances come up at 2.5 percent.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lvl <= {N_CH{smf_pkg::SMOOTH_RST}};
         dual <= '0;
         tol_abs <= {N_PAIR{smf_pkg::TOL_RST}};
         tol_rel <= {N_PAIR{smf_pkg::TOL_RST}};
         rdata <= '0;
      end else begin
         lvl <= next_lvl;
         dual <= next_dual;
         tol_abs <= next_abs;
         tol_rel <= next_rel;
         rdata <= next_rdata;
      end
   end

   assign dual_eval = dual;
   assign tol_abs_values = tol_abs;
   assign tol_rel_values = tol_rel;

   ////////////////////////////////////////////////////////////////////////
   // Per channel averagers.

   logic ch_ok; // Channel number names a real channel.
   logic take; // Buffered sample is consumed this cycle.
   logic [N_CH-1:0] push; // Good sample for a channel.
   logic [N_CH-1:0] restart; // Window restart for a channel.
   logic [W-1:0] mean [N_CH]; // Current mean per channel.

   assign ch_ok = (f_ch < 3'(N_CH));
   assign take = f_valid && f_ready;

   // Each channel owns its window so a restart stays local.
   for (genvar i = 0; i < N_CH; i++) begin : g_ch
      avg_if link();
      // A faulted or out of range sample is dropped and restarts the
      // window; discrepancy is deliberately not a restart cause.
      assign push[i] = take && f_ch == 3'(i) && !f_fault && !f_oor;
      assign restart[i] = lvl_chg[i] ||
         (take && f_ch == 3'(i) && (f_fault || f_oor));
      assign link.push = push[i];
      assign link.restart = restart[i];
      assign link.level = lvl[i];
      assign link.sample = f_sample;
      assign mean[i] = link.mean;
      assign primed[i] = link.primed;
      chan_avg #(
         .W(W),
         .DEPTH(HIST_DEPTH)
      ) u_avg (
         .clock(clock),
         .nrst(nrst),
         .port(link)
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Result path.

   logic inflight, next_inflight; // Averager updated last cycle.
   logic [2:0] in_ch, next_in_ch; // Channel of that update.
   logic next_p_valid;
   logic [2:0] next_p_ch;
   logic [W-1:0] next_p_value;
   logic [W-1:0] smoothed [N_CH]; // Last released mean per channel.
   logic [W-1:0] next_smoothed [N_CH];

   // One sample in flight keeps the path simple at a third of the peak rate,
   // which is far above any conversion rate.
   assign f_ready = !(p_valid || inflight);

   // Release a mean only from a full window and hold it under stall.
   always_comb begin
      next_inflight = take && ch_ok;
      next_in_ch = take ? f_ch : in_ch;
      next_p_valid = p_valid && !p_ready;
      next_p_ch = p_ch;
      next_p_value = p_value;
      next_smoothed = smoothed;
      next_hart = hart_ok;
      if (inflight && primed[in_ch]) begin
         next_p_valid = 1'b1;
         next_p_ch = in_ch;
         next_p_value = mean[in_ch];
         next_smoothed[in_ch] = mean[in_ch];
      end
      if (take && ch_ok) begin
         // The gate follows the raw sample, not the smoothed one.
         next_hart[f_ch] = (f_sample >= smf_pkg::HART_MIN_CODE);
      end
      next_secondary = redundant && (start_addr > partner_addr);
   end

   // Result state; the bus gate stays shut until a current is measured.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         inflight <= 1'b0;
         in_ch <= '0;
         p_valid <= 1'b0;
         p_ch <= '0;
         p_value <= '0;
         smoothed <= '{default: '0};
         hart_ok <= '0;
         secondary <= 1'b0;
      end else begin
         inflight <= next_inflight;
         in_ch <= next_in_ch;
         p_valid <= next_p_valid;
         p_ch <= next_p_ch;
         p_value <= next_p_value;
         smoothed <= next_smoothed;
         hart_ok <= next_hart;
         secondary <= next_secondary;
      end
   end

   for (genvar i = 0; i < N_CH; i++) begin : g_out
      assign smoothed_values[i*W +: W] = smoothed[i];
   end
   assign smoothed_primed = primed;
   assign hart_enable = hart_ok;
   assign secondary_master = secondary;

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   withhold_value_a: assert property (
      $rose(p_valid) |-> primed[p_ch])
      else $error("value released before window was full");
   bypass_pass_a: assert property (
      take && ch_ok && !f_fault && !f_oor && lvl[f_ch] == 2'h0 && !wr
      |-> ##2 p_valid && p_value == $past(f_sample, 2))
      else $error("bypass changed the sample");
   fault_restart_a: assert property (
      take && ch_ok && (f_fault || f_oor) |=> !primed[$past(f_ch)])
      else $error("fault did not restart the window");
   disc_keep_a: assert property (
      primed[0] && !lvl_chg[0] && !(take && f_ch == 3'h0) |=> primed[0])
      else $error("window lost without a restart");
   smoothed_view_a: assert property (
      $rose(p_valid) |-> smoothed[p_ch] == p_value)
      else $error("discrepancy view differs from value");
   tol_abs_span_a: assert property (
      tol_abs[0] >= smf_pkg::TOL_MIN && tol_abs[0] <= smf_pkg::TOL_MAX)
      else $error("absolute tolerance out of span");
   tol_rel_span_a: assert property (
      tol_rel[0] >= smf_pkg::TOL_MIN && tol_rel[0] <= smf_pkg::TOL_MAX)
      else $error("relative tolerance out of span");
   hart_gate_a: assert property (
      take && ch_ok |=> hart_enable[$past(f_ch)] ==
         ($past(f_sample) >= smf_pkg::HART_MIN_CODE))
      else $error("bus gate does not follow loop current");
   role_pick_a: assert property (
      redundant && start_addr > partner_addr |=> secondary_master)
      else $error("higher start address not secondary");
   stall_hold_a: assert property (
      p_valid && !p_ready |=> p_valid && $stable(p_value))
      else $error("value dropped under stall");

   cover property (take && ch_ok && lvl[f_ch] == 2'h3);
   cover property (p_valid && !p_ready ##1 p_valid && p_ready);
   cover property (take && f_fault);
   cover property ($rose(secondary_master));
endmodule // channel_smoothing_filter

// [tb/smf_partner.sv]
`timescale 1ns/10ps
// Stand-in for the converter sequencer and the fail-safe controller.
module smf_partner (
   input wire logic clock,
   input wire logic s_ready,
   output logic s_valid,
   output logic [2:0] s_ch,
   output logic [15:0] s_data,
   output logic [2:0] s_flags,
   output logic p_ready,
   input wire logic stall,
   input wire logic slow
);
   logic [1:0] tick = 2'h0; // Paces the slow controller.
   initial begin
      s_valid = 1'b0;
      s_ch = 3'h0;
      s_data = 16'h0000;
      s_flags = 3'h0;
      p_ready = 1'b0;
   end
   // The controller takes values promptly, slowly, or not at all.
   always @(posedge clock) begin
      tick <= tick + 2'h1;
      p_ready <= !stall && (!slow || tick[1]);
   end
   // Holds a sample until the edge that takes it. The idle bus shows
   // the inverse so a stale sample is never taken for a fresh one.
   task automatic send(input logic [2:0] ch, input logic [15:0] d,
         input logic [2:0] f, output logic ok);
      int n;
      n = 0;
      s_valid <= 1'b1;
      s_ch <= ch;
      s_data <= d;
      s_flags <= f;
      do begin
         @(posedge clock);
         n++;
      end while (!s_ready && n < 300);
      ok = s_ready;
      s_valid <= 1'b0;
      s_data <= ~d;
      s_flags <= 3'h0;
      @(posedge clock);
   endtask
endmodule // smf_partner

// [tb/testbench.sv]
`timescale 1ns/10ps
// Self-checking bench: drivers note expectations, a monitor compares.
module testbench;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic s_valid, s_ready, p_valid, p_ready, secondary_master;
   logic [2:0] s_ch, flags, p_ch, dual_eval;
   logic [15:0] s_data, p_value;
   logic [95:0] smoothed_values;
   logic [5:0] smoothed_primed, hart_enable;
   logic [23:0] tol_abs_values, tol_rel_values;
   logic [2:0] discrepancy = 3'h0;
   logic redundant = 1'b0;
   logic [9:0] start_addr = 10'h000;
   logic [9:0] partner_addr = 10'h000;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0;
   logic stall = 1'b0;
   logic slow = 1'b0;
   logic [31:0] rdata, m, lfsr_state = 32'h4a74_6c4f;
   int fail_count = 0;
   int checks = 0;
   int lvl [6] = '{default: 0}; // Level code per channel.
   logic [15:0] hist [6][$]; // Samples of the open window.
   logic [15:0] last [6]; // Latest expected mean.
   logic [18:0] pv, pv_q[$]; // Expected {channel, value}.
   logic [31:0] rd_q[$], rm_q[$]; // Expected read data and mask.
   int ta [6] = '{4, 5, 6, 8, 9, 10};
   int tw [6] = '{0, 255, 2, 201, 200, 100};
   int te [6] = '{2, 200, 2, 200, 200, 100};
   int sa [4] = '{200, 100, 150, 200};
   int pa [4] = '{100, 200, 150, 100};

   always #2 clock = ~clock;

   channel_smoothing_filter dut_u (.clock(clock), .nrst(nrst),
      .s_valid(s_valid), .s_ready(s_ready), .s_ch(s_ch), .s_data(s_data),
      .s_short(flags[0]), .s_wire_break(flags[1]),
      .s_out_of_range(flags[2]), .p_valid(p_valid), .p_ready(p_ready),
      .p_ch(p_ch), .p_value(p_value), .smoothed_values(smoothed_values),
      .smoothed_primed(smoothed_primed), .dual_eval(dual_eval),
      .tol_abs_values(tol_abs_values), .tol_rel_values(tol_rel_values),
      .discrepancy(discrepancy), .hart_enable(hart_enable),
      .redundant(redundant), .start_addr(start_addr),
      .partner_addr(partner_addr), .secondary_master(secondary_master),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

   smf_partner partner_u (.clock(clock), .s_ready(s_ready),
      .s_valid(s_valid), .s_ch(s_ch), .s_data(s_data), .s_flags(flags),
      .p_ready(p_ready), .stall(stall), .slow(slow));

   ////////////////////////////////////////////////////////////////////
   // Shared tasks.
   function automatic logic [15:0] rnd();
      lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21]
         ^ lfsr_state[1] ^ lfsr_state[0]};
      return lfsr_state[15:0];
   endfunction
   task automatic cmp(input string what, input logic [31:0] e,
         input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic summarize();
      $display("Checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // A wait that ran out ends the run at once.
   task automatic bail(input string what);
      fail_count++;
      $display("Error %s expected done seen timeout", what);
      summarize();
   endtask
   // An edge passes after each strobe so strobes never merge.
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [31:0] e,
         input logic [31:0] mk);
      rd_q.push_back(e);
      rm_q.push_back(mk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(posedge clock);
   endtask
   // Level change restarts only the channel that changed.
   task automatic set_lvl(input int ch, input int l);
      logic [31:0] w;
      w = 32'h0;
      lvl[ch] = l;
      hist[ch].delete();
      for (int i = 0; i < 6; i++) w[2*i +: 2] = 2'(lvl[i]);
      reg_wr(smf_pkg::ADDR_SMOOTH, w);
   endtask
   // Notes the expected mean before the sample is offered.
   task automatic put(input int ch, input logic [15:0] d,
         input logic [2:0] f);
      logic [21:0] sum;
      logic ok;
      int n;
      n = 1 << (2 * lvl[ch % 6]);
      if (ch < 6 && f != 3'h0) begin
         hist[ch].delete();
      end else if (ch < 6) begin
         hist[ch].push_back(d);
         if (hist[ch].size() > n) void'(hist[ch].pop_front());
         if (hist[ch].size() == n) begin
            sum = 22'h0;
            for (int i = 0; i < hist[ch].size(); i++) sum += 22'(hist[ch][i]);
            last[ch] = 16'(sum >> (2 * lvl[ch]));
            pv_q.push_back({3'(ch), last[ch]});
         end
      end
      partner_u.send(3'(ch), d, f, ok);
      if (!ok) bail("sample taken");
   endtask
   task automatic drain();
      int n;
      n = 0;
      while ((pv_q.size() != 0 || p_valid !== 1'b0) && n < 2000) begin
         @(posedge clock);
         n++;
      end
      if (n == 2000) bail("drain");
      repeat (3) @(posedge clock);
   endtask
   task automatic done(input string name);
      $display("Test %s finished", name);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Monitor: read data stands only in the cycle after the strobe.
   always @(posedge clock) begin
      rd_d <= rd;
      if (rd_d) begin
         m = rm_q.pop_front();
         cmp("rdata", rd_q.pop_front() & m, rdata & m);
      end
      if (p_valid === 1'b1 && p_ready === 1'b1) begin
         pv = pv_q.size() != 0 ? pv_q.pop_front() : 19'h7_FFFF;
         cmp("process value", 32'(pv), 32'({p_ch, p_value}));
      end
   end

   initial begin
      repeat (100000) @(posedge clock);
      bail("run");
   end

   ////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      logic full;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      for (int a = 4; a < 11; a++)
         if (a != 7) reg_rd(4'(a), 32'h19, 32'hFFFF_FFFF);
      reg_rd(smf_pkg::ADDR_SMOOTH, 32'h0, 32'hFFFF_FFFF);
      reg_rd(4'h3, 32'h0, 32'hFFFF_FFFF);
      cmp("hart_enable", 32'h0, 32'(hart_enable));
      done("reset");
      for (int i = 0; i < 6; i++) put(0, rnd(), 3'h0);
      slow <= 1'b1;
      for (int l = 1; l < 4; l++) begin
         set_lvl(1, l);
         for (int i = 0; i < (1 << 2 * l) + 3; i++) begin
            put(1, rnd(), 3'h0);
            if (i % 8 == 3) put(2, rnd(), {2'h0, i[4]});
         end
         drain();
      end
      cmp("smoothed", 32'(last[1]), 32'(smoothed_values[31:16]));
      cmp("primed", 32'h1, 32'(smoothed_primed[1]));
      done("levels");
      set_lvl(1, 1);
      for (int f = 0; f < 3; f++) begin
         repeat (5) put(1, rnd(), 3'h0);
         put(1, rnd(), 3'(1 << f));
         put(7 - f % 2, rnd(), 3'h0);
         repeat (2) put(1, rnd(), 3'h0);
         drain();
         cmp("primed", 32'h0, 32'(smoothed_primed[1]));
      end
      done("faults");
      repeat (2) put(1, rnd(), 3'h0);
      discrepancy <= 3'h2;
      repeat (3) put(1, rnd(), 3'h0);
      drain();
      reg_rd(smf_pkg::ADDR_STATUS, 32'h0002_0002, 32'h0007_0002);
      reg_wr(smf_pkg::ADDR_EVAL, 32'h5);
      reg_rd(smf_pkg::ADDR_EVAL, 32'h5, 32'h7);
      cmp("dual_eval", 32'h5, 32'(dual_eval));
      discrepancy <= 3'h0;
      done("discrepancy");
      for (int i = 0; i < 6; i++) begin
         reg_wr(4'(ta[i]), 32'(tw[i]));
         reg_rd(4'(ta[i]), 32'(te[i]), 32'hFFFF_FFFF);
      end
      reg_wr(4'hF, 32'hFFFF_FFFF);
      reg_rd(4'hF, 32'h0, 32'hFFFF_FFFF);
      cmp("tol_abs", 32'h0002_C802, 32'(tol_abs_values));
      cmp("tol_rel", 32'h0064_C8C8, 32'(tol_rel_values));
      for (int i = 0; i < 4; i++) begin
         redundant <= i != 3;
         start_addr <= 10'(sa[i]);
         partner_addr <= 10'(pa[i]);
         repeat (3) @(posedge clock);
         cmp("secondary", 32'(i == 0), 32'(secondary_master));
      end
      done("settings");
      for (int i = 0; i < 3; i++) begin
         put(0, smf_pkg::HART_MIN_CODE - 16'(i % 2), 3'h0);
         drain();
         cmp("hart", 32'(i % 2 == 0), 32'(hart_enable[0]));
      end
      done("hart");
      // The controller stalls so the buffer must fill and refuse.
      stall <= 1'b1;
      slow <= 1'b0;
      fork
         for (int i = 0; i < 20; i++) put(3, rnd(), 3'h0);
      join_none
      full = 1'b0;
      for (int n = 0; n < 200 && !full; n++) begin
         @(posedge clock);
         full = !s_ready;
      end
      cmp("buffer refuses", 32'h1, 32'(full));
      stall <= 1'b0;
      slow <= 1'b1;
      wait fork;
      drain();
      cmp("buffer empty", 32'h1, 32'(s_ready));
      done("buffer");
      set_lvl(1, 2);
      repeat (3) put(1, rnd(), 3'h0);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         lvl[i] = 0;
         hist[i].delete();
      end
      @(posedge clock);
      cmp("primed", 32'h0, 32'(smoothed_primed));
      reg_rd(smf_pkg::ADDR_SMOOTH, 32'h0, 32'hFFFF_FFFF);
      put(1, 16'h1234, 3'h0);
      drain();
      done("restart");
      summarize();
   end
endmodule // testbench
